// file: vebc_defines.vh
// constants for the video enhancer control block: bus addresses, fields, timing
// assumes inclusion by bare name from every design file of the block
`ifndef VEBC_DEFINES_VH
`define VEBC_DEFINES_VH
`define VEBC_SUB_CTRL 3'h0
`define VEBC_SUB_PEAK 3'h1
`define VEBC_SUB_STEEP 3'h2
`define VEBC_SUB_CORE 3'h3
`define VEBC_SUB_LWID 3'h4
`define VEBC_SUB_STAT 3'h0
`define VEBC_SUB_RES1 3'h1
`define VEBC_SUB_RES2 3'h2
`define VEBC_CTL_BUS 0
`define VEBC_CTL_LUMA 1
`define VEBC_CTL_LINE 2
`define VEBC_CTL_FILT 3
`define VEBC_ADDR_FIXED 7'h20
`define VEBC_ADDR_SEL_MASK 7'h50
`define VEBC_VERSION 3'h5
`define VEBC_RESULT_ZERO 6'h00
`define VEBC_LEVEL_ZERO 6'h00
`define VEBC_SAR_STEPS 3'h6
`define VEBC_SAR_SETTLE 2'h3
`define VEBC_STRAP_WAIT 2'h2
`define VEBC_ENV_SHIFT 1
`endif

// file: vebc_sar_adc.v
// 6-bit successive approximation sequencer
// assumes an external comparator: cmp_high is 1 when input exceeds dac_code
`timescale 1ns/1ps
`include "vebc_defines.vh"
module vebc_sar_adc (
  input wire clk,
  input wire rst_n,
  input wire start,
  input wire cmp_high,
  output reg [5:0] dac_code,
  output reg busy,
  output reg done,
  output reg [5:0] result
);
  reg [5:0] bit_reg;
  reg [1:0] settle_reg;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dac_code <= 6'h00;
      bit_reg <= 6'h00;
      settle_reg <= 2'h0;
      busy <= 1'b0;
      done <= 1'b0;
      result <= 6'h00;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
        bit_reg <= 6'h20;
        dac_code <= 6'h20;
        settle_reg <= `VEBC_SAR_SETTLE;
      end else if (busy && settle_reg != 2'h0) begin
        // comparator answer lags the trial by the output register and synchroniser
        settle_reg <= settle_reg - 2'h1;
      end else if (busy) begin
        settle_reg <= `VEBC_SAR_SETTLE;
        // keep or drop the trial bit, then try the next lower one
        if (!cmp_high) begin
          dac_code <= (dac_code & ~bit_reg) | (bit_reg >> 1);
        end else begin
          dac_code <= dac_code | (bit_reg >> 1);
        end
        bit_reg <= bit_reg >> 1;
        if (bit_reg == 6'h01) begin
          busy <= 1'b0;
          done <= 1'b1;
          result <= cmp_high ? dac_code : (dac_code & ~bit_reg);
        end
      end
    end
  end
endmodule // vebc_sar_adc

// file: vebc_i2c_slave.v
// two-wire bus slave byte engine: start/stop, address, ack, data bytes
// assumes scl and sda inputs already synchronised to clk
`timescale 1ns/1ps
`include "vebc_defines.vh"
module vebc_i2c_slave (
  input wire clk,
  input wire rst_n,
  input wire scl,
  input wire sda,
  input wire [6:0] own_addr,
  input wire [7:0] tx_byte,
  output reg sda_oe,
  output reg rx_valid,
  output reg [7:0] rx_byte,
  output reg rx_first,
  output reg tx_taken,
  output reg rd_start,
  output reg bus_end
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_ADDR = 4'b0010;
  localparam ST_WR = 4'b0100;
  localparam ST_RD = 4'b1000;
  reg [3:0] state_reg;
  reg scl_d, sda_d;
  reg [3:0] cnt_reg;
  reg [7:0] sh_reg;
  reg ack_ph, first_reg, nack_reg;
  wire scl_rise = scl & ~scl_d;
  wire scl_fall = ~scl & scl_d;
  wire start_c = scl & scl_d & sda_d & ~sda;
  wire stop_c = scl & scl_d & ~sda_d & sda;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      ack_ph <= 1'b0;
      first_reg <= 1'b0;
      nack_reg <= 1'b0;
      sda_oe <= 1'b0;
      rx_valid <= 1'b0;
      rx_byte <= 8'h00;
      rx_first <= 1'b0;
      tx_taken <= 1'b0;
      rd_start <= 1'b0;
      bus_end <= 1'b0;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
      rx_valid <= 1'b0;
      tx_taken <= 1'b0;
      rd_start <= 1'b0;
      bus_end <= 1'b0;
      if (start_c) begin
        state_reg <= ST_ADDR;
        cnt_reg <= 4'h0;
        ack_ph <= 1'b0;
        sda_oe <= 1'b0;
      end else if (stop_c) begin
        state_reg <= ST_IDLE;
        sda_oe <= 1'b0;
        bus_end <= 1'b1;
      end else begin
        case (state_reg)
          ST_IDLE: sda_oe <= 1'b0;
          ST_ADDR, ST_WR: begin
            if (scl_rise && !ack_ph) begin
              sh_reg <= {sh_reg[6:0], sda};
              cnt_reg <= cnt_reg + 4'h1;
            end else if (scl_fall && !ack_ph && cnt_reg == 4'h8) begin
              ack_ph <= 1'b1;
              cnt_reg <= 4'h0;
              if (state_reg == ST_ADDR) begin
                if (sh_reg[7:1] == own_addr) begin
                  sda_oe <= 1'b1;
                  first_reg <= 1'b1;
                  if (sh_reg[0]) begin
                    rd_start <= 1'b1;
                  end
                end else begin
                  state_reg <= ST_IDLE;
                  bus_end <= 1'b1;
                end
              end else begin
                sda_oe <= 1'b1;
                rx_valid <= 1'b1;
                rx_byte <= sh_reg;
                rx_first <= first_reg;
                first_reg <= 1'b0;
              end
            end else if (scl_fall && ack_ph) begin
              ack_ph <= 1'b0;
              if (state_reg == ST_ADDR && sh_reg[0]) begin
                state_reg <= ST_RD;
                sh_reg <= tx_byte;
                tx_taken <= 1'b1;
                sda_oe <= ~tx_byte[7];
              end else begin
                state_reg <= ST_WR;
                sda_oe <= 1'b0;
              end
            end
          end
          ST_RD: begin
            if (scl_rise && ack_ph) begin
              nack_reg <= sda;
            end else if (scl_rise) begin
              cnt_reg <= cnt_reg + 4'h1;
            end else if (scl_fall && !ack_ph && cnt_reg == 4'h8) begin
              ack_ph <= 1'b1;
              cnt_reg <= 4'h0;
              sda_oe <= 1'b0;
            end else if (scl_fall && !ack_ph) begin
              sh_reg <= {sh_reg[6:0], 1'b1};
              sda_oe <= ~sh_reg[6];
            end else if (scl_fall && ack_ph) begin
              ack_ph <= 1'b0;
              if (nack_reg) begin
                state_reg <= ST_IDLE;
                sda_oe <= 1'b0;
                bus_end <= 1'b1;
              end else begin
                sh_reg <= tx_byte;
                tx_taken <= 1'b1;
                sda_oe <= ~tx_byte[7];
              end
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // vebc_i2c_slave

// file: vebc_top.v
// What this block does
// - one 6-bit SAR converter serves both analog inputs via a two-way mux.
// - mux flips to the other input once every field.
// - each flyback that arrives with the converter idle starts a conversion; result goes to that input's register.
// - read colliding with an update clears that register's valid flag.
// - result byte is 0, valid flag, then 6-bit code.
// - code is linear, zero volts to half reference.
// - power-up clears the bus-control bit so pins rule.
// - in pin mode the slave still acks its address and accesses.
// - bus-control bit set means settings come from registers, pins ignored.
// - noise control input acts in both modes.
// - power-loss flag sets on supply loss, clears only by status read.
// - status shows fixed version code in bits 3..1, zeros above.
// - writes go direct or in bursts, subaddress increments per byte.
// - reads always start at subaddress 0 and auto-increment.
// - address 40H with select low, E0H high; select drives A6 and A4.
// - control bits 1..3 pick luma range, line rate, filter; 7..4 ignored.
// - four 6-bit levels at subaddresses 1..4, linear 0 to 100 percent.
// - envelope reduces applied peaking on large excursions.
// top: register bank, setting select, converter sequencing
// assumes scl, sda, pins and comparator are asynchronous; flyback is same-clock
`timescale 1ns/1ps
`include "vebc_defines.vh"
module vebc_top (
  input wire clk,
  input wire rst_n,
  input wire scl_in,
  input wire sda_in,
  output reg sda_oe,
  input wire addr_select_pin,
  input wire flyback_strobe,
  input wire supply_lost,
  input wire adc_cmp_high,
  output reg adc_input_sel,
  output reg [5:0] adc_dac_code,
  input wire luma_range_pin,
  input wire line_rate_pin,
  input wire contour_filter_pin,
  input wire [5:0] peaking_pin,
  input wire [5:0] steepness_pin,
  input wire [5:0] coring_pin,
  input wire [5:0] line_width_pin,
  input wire [5:0] noise_control_input,
  input wire [5:0] envelope_level,
  output reg luma_range_select,
  output reg line_rate_select,
  output reg contour_filter_select,
  output reg [5:0] peaking_applied,
  output reg [5:0] steepness_applied,
  output reg [5:0] coring_applied,
  output reg [5:0] line_width_setting,
  output reg bus_control_select
);
  reg rst_s1, rst_sync_n;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1 <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_sync_n <= rst_s1;
    end
  end

  // two-stage synchronisers for every asynchronous input
  localparam NSYNC = 32;
  wire [NSYNC-1:0] async_in = {scl_in, sda_in, addr_select_pin, supply_lost, adc_cmp_high,
    luma_range_pin, line_rate_pin, contour_filter_pin, peaking_pin, steepness_pin,
    coring_pin, line_width_pin};
  reg [NSYNC-1:0] sync1, sync2;
  genvar g;
  generate
    for (g = 0; g < NSYNC; g = g + 1) begin : gen_sync
      always @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          sync1[g] <= 1'b1;
          sync2[g] <= 1'b1;
        end else begin
          sync1[g] <= async_in[g];
          sync2[g] <= sync1[g];
        end
      end
    end
  endgenerate
  wire scl_s = sync2[31];
  wire sda_s = sync2[30];
  wire adr_s = sync2[29];
  wire lost_s = sync2[28];
  wire cmp_s = sync2[27];
  wire luma_p = sync2[26];
  wire line_p = sync2[25];
  wire filt_p = sync2[24];
  wire [5:0] peak_p = sync2[23:18];
  wire [5:0] steep_p = sync2[17:12];
  wire [5:0] core_p = sync2[11:6];
  wire [5:0] lwid_p = sync2[5:0];

  // peaking and steepness scaled by noise control, which acts in either mode
  function [5:0] scale6;
    input [5:0] lvl;
    input [5:0] k;
    reg [11:0] p;
    begin
      p = lvl * (6'h3F - k);
      scale6 = p[11:6];
    end
  endfunction

  reg [6:0] own_addr_reg;
  wire [7:0] tx_byte;
  wire rx_valid, rx_first, tx_taken, rd_start, bus_end, sl_oe;
  wire [7:0] rx_byte;
  vebc_i2c_slave u_slave (
    .clk(clk),
    .rst_n(rst_sync_n),
    .scl(scl_s),
    .sda(sda_s),
    .own_addr(own_addr_reg),
    .tx_byte(tx_byte),
    .sda_oe(sl_oe),
    .rx_valid(rx_valid),
    .rx_byte(rx_byte),
    .rx_first(rx_first),
    .tx_taken(tx_taken),
    .rd_start(rd_start),
    .bus_end(bus_end)
  );

  wire adc_busy, adc_done;
  wire [5:0] adc_result, dac_w;
  vebc_sar_adc u_adc (
    .clk(clk),
    .rst_n(rst_sync_n),
    .start(flyback_strobe),
    .cmp_high(cmp_s),
    .dac_code(dac_w),
    .busy(adc_busy),
    .done(adc_done),
    .result(adc_result)
  );

  reg [7:0] mode_control_reg;
  reg [5:0] peaking_level_reg, steepness_level_reg, coring_level_reg, line_width_level_reg;
  reg power_loss_flag_reg;
  reg [5:0] result_one_reg, result_two_reg;
  reg valid_one_reg, valid_two_reg;
  reg [2:0] wr_sub_reg, rd_sub_reg;
  reg conv_sel_reg;
  reg addr_seen_reg;
  reg [1:0] strap_wait_reg;

  assign tx_byte = (rd_sub_reg == `VEBC_SUB_STAT) ?
      {4'h0, `VEBC_VERSION, power_loss_flag_reg} :
    (rd_sub_reg == `VEBC_SUB_RES1) ? {1'b0, valid_one_reg, result_one_reg} :
    (rd_sub_reg == `VEBC_SUB_RES2) ? {1'b0, valid_two_reg, result_two_reg} :
    8'h00;

  wire read_one = tx_taken && rd_sub_reg == `VEBC_SUB_RES1;
  wire read_two = tx_taken && rd_sub_reg == `VEBC_SUB_RES2;
  wire store_one = adc_done && !conv_sel_reg;
  wire store_two = adc_done && conv_sel_reg;

  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      own_addr_reg <= `VEBC_ADDR_FIXED;
      addr_seen_reg <= 1'b0;
      strap_wait_reg <= 2'h0;
      mode_control_reg <= 8'h00;
      peaking_level_reg <= `VEBC_LEVEL_ZERO;
      steepness_level_reg <= `VEBC_LEVEL_ZERO;
      coring_level_reg <= `VEBC_LEVEL_ZERO;
      line_width_level_reg <= `VEBC_LEVEL_ZERO;
      power_loss_flag_reg <= 1'b1;
      result_one_reg <= `VEBC_RESULT_ZERO;
      result_two_reg <= `VEBC_RESULT_ZERO;
      valid_one_reg <= 1'b0;
      valid_two_reg <= 1'b0;
      wr_sub_reg <= 3'h0;
      rd_sub_reg <= 3'h0;
      conv_sel_reg <= 1'b0;
      adc_input_sel <= 1'b0;
    end else begin
      // strap read once the synchroniser holds the pin, not its reset value
      if (!addr_seen_reg) begin
        if (strap_wait_reg == `VEBC_STRAP_WAIT) begin
          addr_seen_reg <= 1'b1;
          own_addr_reg <= `VEBC_ADDR_FIXED | (adr_s ? `VEBC_ADDR_SEL_MASK : 7'h00);
        end else begin
          strap_wait_reg <= strap_wait_reg + 2'h1;
        end
      end
      // writes: first byte is the subaddress, following bytes auto-increment
      if (rx_valid && rx_first) begin
        wr_sub_reg <= rx_byte[2:0];
      end else if (rx_valid) begin
        case (wr_sub_reg)
          `VEBC_SUB_CTRL: mode_control_reg <= {4'h0, rx_byte[3:0]};
          `VEBC_SUB_PEAK: peaking_level_reg <= rx_byte[5:0];
          `VEBC_SUB_STEEP: steepness_level_reg <= rx_byte[5:0];
          `VEBC_SUB_CORE: coring_level_reg <= rx_byte[5:0];
          `VEBC_SUB_LWID: line_width_level_reg <= rx_byte[5:0];
          default: ;
        endcase
        wr_sub_reg <= wr_sub_reg + 3'h1;
      end
      // reads restart at zero on each read address phase
      if (rd_start) begin
        rd_sub_reg <= 3'h0;
      end else if (tx_taken) begin
        rd_sub_reg <= rd_sub_reg + 3'h1;
      end
      // set wins over the read clear
      if (lost_s) begin
        power_loss_flag_reg <= 1'b1;
      end else if (tx_taken && rd_sub_reg == `VEBC_SUB_STAT) begin
        power_loss_flag_reg <= 1'b0;
      end
      // collision: update in the very cycle the byte is taken marks it invalid
      if (store_one) begin
        result_one_reg <= adc_result;
        valid_one_reg <= !read_one;
      end
      if (store_two) begin
        result_two_reg <= adc_result;
        valid_two_reg <= !read_two;
      end
      // select flips as each accepted flyback starts its conversion
      if (flyback_strobe && !adc_busy) begin
        adc_input_sel <= ~conv_sel_reg;
        conv_sel_reg <= ~conv_sel_reg;
      end
    end
  end

  wire bus_mode = mode_control_reg[`VEBC_CTL_BUS];
  wire [5:0] peak_src = bus_mode ? peaking_level_reg : peak_p;
  wire [5:0] env_cut = envelope_level >> `VEBC_ENV_SHIFT;
  wire [5:0] peak_env = (peak_src > env_cut) ? peak_src - env_cut : 6'h00;

  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sda_oe <= 1'b0;
      adc_dac_code <= 6'h00;
      luma_range_select <= 1'b0;
      line_rate_select <= 1'b0;
      contour_filter_select <= 1'b0;
      peaking_applied <= 6'h00;
      steepness_applied <= 6'h00;
      coring_applied <= 6'h00;
      line_width_setting <= 6'h00;
      bus_control_select <= 1'b0;
    end else begin
      sda_oe <= sl_oe;
      adc_dac_code <= dac_w;
      bus_control_select <= bus_mode;
      luma_range_select <= bus_mode ? mode_control_reg[`VEBC_CTL_LUMA] : luma_p;
      line_rate_select <= bus_mode ? mode_control_reg[`VEBC_CTL_LINE] : line_p;
      contour_filter_select <= bus_mode ? mode_control_reg[`VEBC_CTL_FILT] : filt_p;
      peaking_applied <= scale6(peak_env, noise_control_input);
      steepness_applied <= scale6(bus_mode ? steepness_level_reg : steep_p,
        noise_control_input);
      coring_applied <= bus_mode ? coring_level_reg : core_p;
      line_width_setting <= bus_mode ? line_width_level_reg : lwid_p;
    end
  end
endmodule // vebc_top

// file: vebc_i2c_master.sv
// two-wire bus master model: start, stop and one byte with its ninth bit
// assumes the bench resolves the open-drain data line with a pull-up
`timescale 1ns/1ps
module vebc_i2c_master (
  input wire clk,
  input wire sda_line,
  output logic scl,
  output logic sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task q;
    repeat (6) @(posedge clk);
  endtask
  // data only moves with scl low, so the slave never sees a false frame edge
  task bit_io(input logic low, output logic v);
    sda_low <= low;
    q;
    scl <= 1'b1;
    q;
    v = sda_line;
    q;
    scl <= 1'b0;
    q;
  endtask
  task start;
    sda_low <= 1'b1;
    q;
    scl <= 1'b0;
    q;
  endtask
  task stop;
    sda_low <= 1'b1;
    q;
    scl <= 1'b1;
    q;
    sda_low <= 1'b0;
    q;
  endtask
  // a read passes 8'hFF so the line stays released for the slave
  task xb(input logic [7:0] b, input logic mack, output logic [7:0] r, output logic ack);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      bit_io(~b[i], r[i]);
    end
    bit_io(mack, v);
    ack = ~v;
  endtask
endmodule // vebc_i2c_master

// file: vebc_top_asserts.sv
// concurrent checks on the control block top: mode select, ack hold, converter
// assumes binding onto vebc_top, one clock domain
`timescale 1ns/1ps
module vebc_top_asserts (
  input wire clk,
  input wire rst_n,
  input wire scl_in,
  input wire sda_oe,
  input wire flyback_strobe,
  input wire adc_input_sel,
  input wire [5:0] adc_dac_code,
  input wire luma_range_pin,
  input wire line_rate_pin,
  input wire [5:0] peaking_pin,
  input wire [5:0] envelope_level,
  input wire luma_range_select,
  input wire line_rate_select,
  input wire [5:0] peaking_applied,
  input wire bus_control_select
);
  logic [3:0] up_cnt;
  logic [5:0] fly_cnt;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      up_cnt <= 4'h0;
      fly_cnt <= 6'h3F;
    end else begin
      if (up_cnt != 4'hF) up_cnt <= up_cnt + 4'h1;
      if (flyback_strobe) fly_cnt <= 6'h00;
      else if (fly_cnt != 6'h3F) fly_cnt <= fly_cnt + 6'h01;
    end
  end
  // pin paths need a few cycles after reset before they settle
  wire up = up_cnt == 4'hF;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_reset_pin_mode: assert property ($rose(rst_n) |-> !bus_control_select ##1 !bus_control_select)
    else $error("bus control set after reset");
  a_pin_follow: assert property ((up && !bus_control_select && $stable(luma_range_pin))[*5]
    |-> luma_range_select == luma_range_pin) else $error("luma select ignores pin");
  a_bus_ignores_pin: assert property (bus_control_select && $changed(line_rate_pin)
    |=> ($stable(line_rate_select) || !bus_control_select)[*5]) else $error("pin leaks in bus mode");
  a_sda_hold_high: assert property (scl_in[*5] |-> $stable(sda_oe))
    else $error("sda moved with scl high");
  a_mux_toggle: assert property (flyback_strobe |=> $changed(adc_input_sel))
    else $error("mux did not toggle");
  a_mux_steady: assert property (fly_cnt > 6'h14 |-> $stable(adc_input_sel))
    else $error("mux moved between fields");
  a_sar_first_trial: assert property (flyback_strobe |-> ##[1:4] adc_dac_code == 6'h20)
    else $error("no midscale trial");
  a_peak_cut: assert property ((up && !bus_control_select && $stable(peaking_pin)
    && $stable(envelope_level) && envelope_level[5:1] <= peaking_pin)[*5]
    |-> {1'b0, peaking_applied} + envelope_level[5:1] <= {1'b0, peaking_pin})
    else $error("envelope did not cut peaking");
  c_field: cover property (flyback_strobe);
  c_ack: cover property ($rose(sda_oe));
  c_bus_mode: cover property ($rose(bus_control_select));
endmodule // vebc_top_asserts
bind vebc_top vebc_top_asserts chk_i (
  .clk(clk), .rst_n(rst_n), .scl_in(scl_in), .sda_oe(sda_oe),
  .flyback_strobe(flyback_strobe), .adc_input_sel(adc_input_sel),
  .adc_dac_code(adc_dac_code), .luma_range_pin(luma_range_pin),
  .line_rate_pin(line_rate_pin), .peaking_pin(peaking_pin),
  .envelope_level(envelope_level), .luma_range_select(luma_range_select),
  .line_rate_select(line_rate_select), .peaking_applied(peaking_applied),
  .bus_control_select(bus_control_select)
);

// file: vebc_top_tb.sv
// self-checking bench: register rows, pin mode, status, converter, address select
// assumes the master model and checker compile ahead of this file
`timescale 1ns/1ps
module vebc_top_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sel = 1'b0;
  logic fly = 1'b0;
  logic lost = 1'b0;
  logic lp = 1'b1;
  logic rp = 1'b1;
  logic cp = 1'b1;
  logic [5:0] pk = 6'h3F, sp = 6'h3F, co = 6'h3F, lw = 6'h2A;
  logic [5:0] nz = 6'h00, env = 6'h00, v1 = 6'h00, v2 = 6'h00;
  logic [7:0] bb [0:5];
  logic [7:0] rb [0:5];
  logic ak;
  int fails = 0;
  int checks = 0;
  wire scl, mlow, sda_oe, isel, la, ra, ca, bc;
  wire [5:0] dac, pka, spa, coa, lwa;
  wire sda = ~(mlow | sda_oe);
  // analog level sits half a step above its code
  wire cmp = (isel ? v2 : v1) >= dac;
  // subaddress, data byte, expected observed byte
  logic [23:0] rows [0:7] = '{24'h000F0F, 24'h00F101, 24'h013F3E, 24'h01C000,
    24'h022A29, 24'h031515, 24'h043F3F, 24'h040000};
  logic [11:0] av [0:1] = '{12'h57F, 12'h02A};
  vebc_top uut (
    .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_oe(sda_oe),
    .addr_select_pin(sel), .flyback_strobe(fly), .supply_lost(lost),
    .adc_cmp_high(cmp), .adc_input_sel(isel), .adc_dac_code(dac),
    .luma_range_pin(lp), .line_rate_pin(rp), .contour_filter_pin(cp),
    .peaking_pin(pk), .steepness_pin(sp), .coring_pin(co), .line_width_pin(lw),
    .noise_control_input(nz), .envelope_level(env), .luma_range_select(la),
    .line_rate_select(ra), .contour_filter_select(ca), .peaking_applied(pka),
    .steepness_applied(spa), .coring_applied(coa), .line_width_setting(lwa),
    .bus_control_select(bc)
  );
  vebc_i2c_master mst (.clk(clk), .sda_line(sda), .scl(scl), .sda_low(mlow));
  always #5 clk = ~clk;
  function logic [5:0] sc(input logic [5:0] l, input logic [5:0] k);
    logic [11:0] p;
    p = l * (6'h3F - k);
    sc = p[11:6];
  endfunction
  function logic [7:0] obs(input logic [2:0] s);
    case (s)
      3'h0: obs = {4'h0, ca, ra, la, bc};
      3'h1: obs = {2'h0, pka};
      3'h2: obs = {2'h0, spa};
      3'h3: obs = {2'h0, coa};
      default: obs = {2'h0, lwa};
    endcase
  endfunction
  task chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t: got %h want %h", $time, g, e);
    end
  endtask
  task fin(input string nm);
    $display("test %s done", nm);
  endtask
  task end_sim;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task tx(input logic [7:0] a, input int n);
    logic k;
    mst.start;
    mst.xb(a, 1'b0, rb[0], ak);
    for (int i = 0; i < n; i++) begin
      mst.xb(a[0] ? 8'hFF : bb[i], a[0] && i < n - 1, rb[i], k);
      if (!a[0]) ak = ak & k;
    end
    mst.stop;
    repeat (8) @(posedge clk);
  endtask
  task field;
    fly <= 1'b1;
    @(posedge clk);
    fly <= 1'b0;
    repeat (40) @(posedge clk);
  endtask
  initial begin
    repeat (7) @(posedge clk);
    chk({la, ra, ca, bc, isel, 3'h0}, 8'h00);
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (12) @(posedge clk);
    chk(obs(3'h0), {4'h0, cp, rp, lp, 1'b0});
    chk(obs(3'h4), {2'h0, lw});
    fin("reset");
    bb[0] = 8'h01;
    bb[1] = 8'h05;
    tx(8'h40, 2);
    chk({7'h0, ak}, 8'h01);
    chk(obs(3'h1), {2'h0, sc(pk, nz)});
    tx(8'h41, 4);
    chk(rb[0], 8'h0B);
    chk(rb[1], 8'h00);
    chk(rb[3], 8'h00);
    tx(8'h41, 1);
    chk(rb[0], 8'h0A);
    lost <= 1'b1;
    repeat (4) @(posedge clk);
    lost <= 1'b0;
    tx(8'h41, 1);
    chk(rb[0], 8'h0B);
    fin("pin mode and status");
    foreach (rows[i]) begin
      bb[0] = rows[i][23:16];
      bb[1] = rows[i][15:8];
      tx(8'h40, 2);
      chk(obs(rows[i][18:16]), rows[i][7:0]);
    end
    rp <= 1'b0;
    repeat (10) @(posedge clk);
    chk(obs(3'h0), 8'h01);
    rp <= 1'b1;
    fin("register rows");
    bb[0] = 8'h01;
    for (int i = 1; i < 5; i++) bb[i] = {i[3:0], 4'h0};
    tx(8'h40, 5);
    for (int i = 1; i < 3; i++) chk(obs(i[2:0]), {2'h0, sc(bb[i][5:0], 6'h00)});
    chk(obs(3'h3), {2'h0, bb[3][5:0]});
    chk(obs(3'h4), 8'h00);
    nz <= 6'h20;
    repeat (6) @(posedge clk);
    chk(obs(3'h2), {2'h0, sc(6'h20, 6'h20)});
    bb[0] = 8'h00;
    bb[1] = 8'h00;
    tx(8'h40, 2);
    chk(obs(3'h2), {2'h0, sc(sp, 6'h20)});
    nz <= 6'h00;
    env <= 6'h10;
    repeat (8) @(posedge clk);
    chk(obs(3'h1), {2'h0, sc(pk, 6'h00) - 6'h08});
    env <= 6'h00;
    fin("burst noise envelope");
    foreach (av[j]) begin
      v1 <= av[j][11:6];
      v2 <= av[j][5:0];
      field;
      field;
      tx(8'h41, 3);
      chk(rb[1], {2'h1, av[j][11:6]});
      chk(rb[2], {2'h1, av[j][5:0]});
      chk({7'h0, isel}, 8'h00);
    end
    fin("converter");
    for (int s = 0; s < 2; s++) begin
      rst_n <= 1'b0;
      sel <= s[0];
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (12) @(posedge clk);
      tx(8'h40, 0);
      chk({7'h0, ak}, {7'h0, ~s[0]});
      tx(8'hE0, 0);
      chk({7'h0, ak}, {7'h0, s[0]});
    end
    fin("address select");
    end_sim;
  end
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    $display("ERROR %0t: watchdog expired", $time);
    end_sim;
  end
endmodule // vebc_top_tb
